/* rtl/crbt_consts.svh */
// Register offsets, field positions, reset values and timing counts of the capture/reload baud timer.
`ifndef CRBT_CONSTS_SVH
`define CRBT_CONSTS_SVH
`define CRBT_CTRL_ADDR      8'hc9
`define CRBT_RCAP_L_ADDR    8'he4
`define CRBT_RCAP_H_ADDR    8'he5
`define CRBT_CNT_L_ADDR     8'he8
`define CRBT_CNT_H_ADDR     8'hf5
`define CRBT_CLKCTL_ADDR    8'h8e
`define CRBT_CTRL_RESET     8'h00
`define CRBT_BIT_OVF        7
`define CRBT_BIT_EXF        6
`define CRBT_BIT_RXSEL      5
`define CRBT_BIT_TXSEL      4
`define CRBT_BIT_EXEN       3
`define CRBT_BIT_RUN        2
`define CRBT_BIT_CT         1
`define CRBT_BIT_CPRL       0
`define CRBT_BIT_DIVSEL     6
`define CRBT_DIV12_TERM     4'hb
`endif

/* rtl/crbt_pkg.sv */
// Types shared by the capture/reload baud timer.
package crbt_pkg;
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } crbt_sfr_req_t;
   typedef enum logic [3:0] {
      CRBT_OFF     = 4'b0001,
      CRBT_CAPTURE = 4'b0010,
      CRBT_RELOAD  = 4'b0100,
      CRBT_BAUD    = 4'b1000
   } crbt_mode_t;
endpackage

/* rtl/crbt_fall_det.sv */
// Two-stage sampler with falling edge detection for one pin.
`timescale 1ns/100ps
`default_nettype none
module crbt_fall_det (
   input  wire logic mclk_i,
   input  wire logic reset_n_i,
   input  wire logic pin_i,
   output var  logic fall_o
);
   logic sync1_reg;
   logic sync2_reg;
   logic prev_reg;
   // The first stage feeds only the second; the edge is judged on later stages.
   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         sync1_reg <= 1'b1;
         sync2_reg <= 1'b1;
         prev_reg  <= 1'b1;
         fall_o    <= 1'b0;
      end else begin
         sync1_reg <= pin_i;
         sync2_reg <= sync1_reg;
         prev_reg  <= sync2_reg;
         fall_o    <= prev_reg & ~sync2_reg; // RULE16
      end
   end
endmodule
`default_nettype wire

/* rtl/crbt_timer.sv */
// Top of the 16-bit capture, auto-reload and baud generator timer.
//
// Behaviour
// RULE1 - Timer counts system clock over 1 or 12, or falling count-pin edges.
// RULE2 - Run bit low halts the count in every mode.
// RULE3 - Capture mode: trigger edge copies count to capture pair, sets external flag.
// RULE4 - Capture when capture select and run set; trigger edges need external enable.
// RULE5 - Capture and reload modes: wrap from all ones sets overflow flag, interrupts.
// RULE6 - Reload mode: each overflow loads reload pair into the counter.
// RULE7 - Reload mode with external enable: trigger edge reloads and sets external flag.
// RULE8 - Either baud select bit forces baud mode, reloading on overflow.
// RULE9 - Baud mode overflow sets no flag; it pulses the serial shift clock.
// RULE10 - Receive select picks timer 1 or this timer for receive clock.
// RULE11 - Transmit select picks timer 1 or this timer for transmit clock.
// RULE12 - Baud mode internal clocking counts at half the system clock.
// RULE13 - Baud mode counter select counts count-pin falling edges.
// RULE14 - Baud mode with external enable: trigger edge sets external flag, interrupts.
// RULE15 - Both flags stay set until software clears them.
// RULE16 - Pins synchronised, falling edges detected once per edge.
`timescale 1ns/100ps
`default_nettype none
`include "crbt_consts.svh"
module crbt_timer (
   input  wire logic                   mclk_i,
   input  wire logic                   reset_n_i,
   input  wire crbt_pkg::crbt_sfr_req_t sfr_i,
   output var  logic [7:0]             sfr_rdata_o,
   input  wire logic                   count_input_pin_i,
   input  wire logic                   trigger_input_pin_i,
   input  wire logic                   timer1_ovf_i,
   output var  logic                   rx_baud_clk_o,
   output var  logic                   tx_baud_clk_o,
   output var  logic                   irq_o
);
   import crbt_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   logic [7:0]  ctrl_reg;
   logic [7:0]  clkctl_reg;
   logic [15:0] count_reg;
   logic [15:0] rcap_reg;
   logic [3:0]  pre_reg;
   logic        half_reg;
   logic        cnt_fall;
   logic        trg_fall;
   crbt_mode_t  mode;

   crbt_fall_det u_cnt (
      .mclk_i    (mclk_i),
      .reset_n_i (reset_n_i),
      .pin_i     (count_input_pin_i),
      .fall_o    (cnt_fall)
   );
   crbt_fall_det u_trg (
      .mclk_i    (mclk_i),
      .reset_n_i (reset_n_i),
      .pin_i     (trigger_input_pin_i),
      .fall_o    (trg_fall)
   );

   ////////////////////////////////////////////////////////////////////////////
   wire run     = ctrl_reg[`CRBT_BIT_RUN];
   wire baud    = ctrl_reg[`CRBT_BIT_RXSEL] | ctrl_reg[`CRBT_BIT_TXSEL]; // RULE8
   wire ext_cnt = ctrl_reg[`CRBT_BIT_CT];
   wire div1    = clkctl_reg[`CRBT_BIT_DIVSEL];

   always_comb begin
      if (!run)
         mode = CRBT_OFF; // RULE2
      else if (baud)
         mode = CRBT_BAUD; // RULE8
      else if (ctrl_reg[`CRBT_BIT_CPRL])
         mode = CRBT_CAPTURE; // RULE4
      else
         mode = CRBT_RELOAD;
   end

   wire pre_tick = (pre_reg == `CRBT_DIV12_TERM);
   // Baud mode runs internally at half rate; otherwise the divide select applies.
   wire int_tick = baud ? half_reg : (div1 | pre_tick); // RULE1 RULE12
   wire tick     = (mode != CRBT_OFF) & (ext_cnt ? cnt_fall : int_tick); // RULE1 RULE2 RULE13
   wire wrap     = tick & (count_reg == 16'hffff);
   wire trg_act  = (mode != CRBT_OFF) & ctrl_reg[`CRBT_BIT_EXEN] & trg_fall; // RULE4
   wire do_cap   = trg_act & (mode == CRBT_CAPTURE); // RULE3
   wire do_rld   = (wrap & (mode != CRBT_CAPTURE)) | (trg_act & (mode == CRBT_RELOAD)); // RULE6 RULE7 RULE8
   wire set_ovf  = wrap & (mode != CRBT_BAUD); // RULE5 RULE9
   wire set_exf  = trg_act; // RULE3 RULE7 RULE14
   wire baud_ovf = wrap & (mode == CRBT_BAUD); // RULE9

   wire wr_ctrl  = sfr_i.wr & (sfr_i.addr == `CRBT_CTRL_ADDR);
   wire wr_clk   = sfr_i.wr & (sfr_i.addr == `CRBT_CLKCTL_ADDR);
   wire wr_rl    = sfr_i.wr & (sfr_i.addr == `CRBT_RCAP_L_ADDR);
   wire wr_rh    = sfr_i.wr & (sfr_i.addr == `CRBT_RCAP_H_ADDR);
   wire wr_cl    = sfr_i.wr & (sfr_i.addr == `CRBT_CNT_L_ADDR);
   wire wr_ch    = sfr_i.wr & (sfr_i.addr == `CRBT_CNT_H_ADDR);

   // Hardware set wins over a software clear written in the same cycle.
   wire [7:0] ctrl_wr = wr_ctrl ? sfr_i.wdata : ctrl_reg;
   wire [7:0] ctrl_next = {ctrl_wr[7] | set_ovf, ctrl_wr[6] | set_exf, ctrl_wr[5:0]}; // RULE15

   wire [15:0] cnt_inc  = count_reg + 16'h0001;
   wire [15:0] cnt_next = do_rld ? rcap_reg :
                          wr_cl  ? {count_reg[15:8], sfr_i.wdata} :
                          wr_ch  ? {sfr_i.wdata, count_reg[7:0]} :
                          tick   ? cnt_inc : count_reg; // RULE6
   wire [15:0] rcap_next = do_cap ? count_reg : // RULE3
                           wr_rl  ? {rcap_reg[15:8], sfr_i.wdata} :
                           wr_rh  ? {sfr_i.wdata, rcap_reg[7:0]} : rcap_reg;

   wire [7:0] rd_mux = (sfr_i.addr == `CRBT_CTRL_ADDR)   ? ctrl_reg :
                       (sfr_i.addr == `CRBT_CLKCTL_ADDR) ? clkctl_reg :
                       (sfr_i.addr == `CRBT_RCAP_L_ADDR) ? rcap_reg[7:0] :
                       (sfr_i.addr == `CRBT_RCAP_H_ADDR) ? rcap_reg[15:8] :
                       (sfr_i.addr == `CRBT_CNT_L_ADDR)  ? count_reg[7:0] :
                       (sfr_i.addr == `CRBT_CNT_H_ADDR)  ? count_reg[15:8] : 8'h00;

   // Timer 1 overflows pass through one register stage when the select bit is clear.
   wire rx_next = ctrl_reg[`CRBT_BIT_RXSEL] ? baud_ovf : timer1_ovf_i; // RULE10
   wire tx_next = ctrl_reg[`CRBT_BIT_TXSEL] ? baud_ovf : timer1_ovf_i; // RULE11
   wire [3:0] pre_next = pre_tick ? 4'h0 : pre_reg + 4'h1;

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         ctrl_reg      <= `CRBT_CTRL_RESET;
         clkctl_reg    <= 8'h00;
         count_reg     <= 16'h0000;
         rcap_reg      <= 16'h0000;
         pre_reg       <= 4'h0;
         half_reg      <= 1'b0;
         sfr_rdata_o   <= 8'h00;
         rx_baud_clk_o <= 1'b0;
         tx_baud_clk_o <= 1'b0;
         irq_o         <= 1'b0;
      end else begin
         ctrl_reg      <= ctrl_next;
         clkctl_reg    <= wr_clk ? sfr_i.wdata : clkctl_reg;
         count_reg     <= cnt_next;
         rcap_reg      <= rcap_next;
         pre_reg       <= pre_next;
         half_reg      <= ~half_reg;
         sfr_rdata_o   <= sfr_i.rd ? rd_mux : sfr_rdata_o;
         rx_baud_clk_o <= rx_next;
         tx_baud_clk_o <= tx_next;
         irq_o         <= ctrl_next[`CRBT_BIT_OVF] | ctrl_next[`CRBT_BIT_EXF];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   sequence s_trigger;
      trg_fall && run && ctrl_reg[`CRBT_BIT_EXEN];
   endsequence

   property p_halt;
      @(posedge mclk_i) disable iff (!reset_n_i)
      (!run && !wr_cl && !wr_ch) |=> $stable(count_reg);
   endproperty
   a_halt: assert property (p_halt) else $error("Counter moved while halted."); // RULE2

   property p_capture;
      @(posedge mclk_i) disable iff (!reset_n_i)
      (s_trigger and (mode == CRBT_CAPTURE)) |=> (rcap_reg == $past(count_reg)) && ctrl_reg[`CRBT_BIT_EXF];
   endproperty
   a_capture: assert property (p_capture) else $error("Capture did not store the count."); // RULE3

   property p_ignore;
      @(posedge mclk_i) disable iff (!reset_n_i)
      (trg_fall && !ctrl_reg[`CRBT_BIT_EXEN] && !set_ovf && !wr_ctrl && !ctrl_reg[`CRBT_BIT_EXF])
         |=> !ctrl_reg[`CRBT_BIT_EXF];
   endproperty
   a_ignore: assert property (p_ignore) else $error("Trigger edge acted while disabled."); // RULE4

   property p_ovf;
      @(posedge mclk_i) disable iff (!reset_n_i)
      (wrap && mode != CRBT_BAUD) |=> ctrl_reg[`CRBT_BIT_OVF];
   endproperty
   a_ovf: assert property (p_ovf) else $error("Wrap did not set overflow flag."); // RULE5

   property p_reload;
      @(posedge mclk_i) disable iff (!reset_n_i)
      (wrap && (mode == CRBT_RELOAD || mode == CRBT_BAUD)) |=> (count_reg == $past(rcap_reg));
   endproperty
   a_reload: assert property (p_reload) else $error("Overflow did not reload the counter."); // RULE6

   property p_trg_reload;
      @(posedge mclk_i) disable iff (!reset_n_i)
      (s_trigger and (mode == CRBT_RELOAD)) |=> (count_reg == $past(rcap_reg));
   endproperty
   a_trg_reload: assert property (p_trg_reload) else $error("Trigger did not reload."); // RULE7

   property p_baud_noflag;
      @(posedge mclk_i) disable iff (!reset_n_i)
      (baud_ovf && !ctrl_reg[`CRBT_BIT_OVF] && !wr_ctrl)
         |=> !ctrl_reg[`CRBT_BIT_OVF] ##0 (rx_baud_clk_o == (ctrl_reg[`CRBT_BIT_RXSEL] | $past(timer1_ovf_i)));
   endproperty
   a_baud_noflag: assert property (p_baud_noflag) else $error("Baud overflow misbehaved."); // RULE9

   property p_half;
      @(posedge mclk_i) disable iff (!reset_n_i)
      (mode == CRBT_BAUD && !ext_cnt && tick) |=> !tick;
   endproperty
   a_half: assert property (p_half) else $error("Baud count faster than half clock."); // RULE12

   property p_sticky;
      @(posedge mclk_i) disable iff (!reset_n_i)
      (ctrl_reg[`CRBT_BIT_EXF] && !wr_ctrl) |=> ctrl_reg[`CRBT_BIT_EXF];
   endproperty
   a_sticky: assert property (p_sticky) else $error("External flag cleared by itself."); // RULE15

   property p_div12;
      @(posedge mclk_i) disable iff (!reset_n_i)
      (tick && !baud && !ext_cnt && !div1 && !wr_clk && !wr_ctrl) |=> !tick;
   endproperty
   a_div12: assert property (p_div12) else $error("Divide by twelve ticked twice in a row."); // RULE1

   property p_rx_timer1;
      @(posedge mclk_i) disable iff (!reset_n_i)
      !ctrl_reg[`CRBT_BIT_RXSEL] |=> (rx_baud_clk_o == $past(timer1_ovf_i));
   endproperty
   a_rx_timer1: assert property (p_rx_timer1) else $error("Receive clock not taken from timer 1."); // RULE10

   property p_tx_timer1;
      @(posedge mclk_i) disable iff (!reset_n_i)
      !ctrl_reg[`CRBT_BIT_TXSEL] |=> (tx_baud_clk_o == $past(timer1_ovf_i));
   endproperty
   a_tx_timer1: assert property (p_tx_timer1) else $error("Transmit clock not taken from timer 1."); // RULE11

   property p_baud_exf;
      @(posedge mclk_i) disable iff (!reset_n_i)
      (s_trigger and (mode == CRBT_BAUD)) |=> ctrl_reg[`CRBT_BIT_EXF];
   endproperty
   a_baud_exf: assert property (p_baud_exf) else $error("Baud mode trigger did not set the flag."); // RULE14
endmodule
`default_nettype wire

/* verif/crbt_pin_model.sv */
// Pin-side model: count pin, trigger pin and timer 1 overflow source.
`timescale 1ns/100ps
`default_nettype none
module crbt_pin_model (
   input  wire logic mclk_i,
   output var  logic count_pin_o,
   output var  logic trigger_pin_o,
   output var  logic timer1_ovf_o
);
   initial begin
      count_pin_o = 1'b1;
      trigger_pin_o = 1'b1;
      timer1_ovf_o = 1'b0;
   end
   ////////////////////////////////////////////////////////////////////////////
   // Low phases last three cycles so a two-stage sampler cannot miss them.
   task automatic fall(input bit trig);
      @(posedge mclk_i);
      #1 if (trig) trigger_pin_o = 1'b0; else count_pin_o = 1'b0;
      repeat (3) @(posedge mclk_i);
      #1 if (trig) trigger_pin_o = 1'b1; else count_pin_o = 1'b1;
      repeat (3) @(posedge mclk_i);
   endtask
   task automatic pulse_t1(input int n);
      repeat (n) begin
         @(posedge mclk_i);
         #1 timer1_ovf_o = 1'b1;
         @(posedge mclk_i);
         #1 timer1_ovf_o = 1'b0;
         @(posedge mclk_i);
      end
   endtask
endmodule
`default_nettype wire

/* verif/tb_crbt_timer.sv */
// Self-checking testbench of the capture/reload baud timer.
`timescale 1ns/100ps
`default_nettype none
`include "crbt_consts.svh"
module tb_crbt_timer;
   import crbt_pkg::*;
   logic          mclk_i = 1'b0;
   logic          reset_n_i = 1'b0;
   crbt_sfr_req_t sfr;
   logic [7:0]    sfr_rdata_o;
   logic          cnt_pin, trig_pin, t1_ovf, rx_clk, tx_clk, irq_o;
   logic [7:0]    exp_q[$];
   logic [7:0]    lo;
   int            fails = 0;
   int            cmp_count = 0;
   int            seed = 13879;
   int            rx_n = 0;
   int            tx_n = 0;
   int            r0;
   int            t0;
   always #25 mclk_i = ~mclk_i;
   crbt_timer dut (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .sfr_i(sfr), .sfr_rdata_o(sfr_rdata_o),
      .count_input_pin_i(cnt_pin), .trigger_input_pin_i(trig_pin), .timer1_ovf_i(t1_ovf),
      .rx_baud_clk_o(rx_clk), .tx_baud_clk_o(tx_clk), .irq_o(irq_o));
   crbt_pin_model pins (.mclk_i(mclk_i), .count_pin_o(cnt_pin), .trigger_pin_o(trig_pin),
      .timer1_ovf_o(t1_ovf));
   ////////////////////////////////////////////////////////////////////////////
   task automatic check(input string name, input logic [7:0] e, input logic [7:0] s);
      cmp_count++;
      if (s !== e) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", name, e, s);
      end
   endtask
   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk_i);
      #1 sfr = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge mclk_i);
      #1 sfr.wr = 1'b0;
   endtask
   // The expected byte is queued first; the watcher below pops it when data lands.
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge mclk_i);
      exp_q.push_back(e);
      #1 sfr = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(posedge mclk_i);
      #1 sfr.rd = 1'b0;
   endtask
   always @(posedge mclk_i) begin
      if (sfr.rd === 1'b1) begin
         #2 check("sfr_rdata_o", exp_q.pop_front(), sfr_rdata_o);
      end
   end
   // Counted on the falling edge, where the one-cycle pulses have settled.
   always @(negedge mclk_i) begin
      if (rx_clk === 1'b1) rx_n++;
      if (tx_clk === 1'b1) tx_n++;
   end
   initial begin
      repeat (20000) @(posedge mclk_i);
      fails++;
      give_verdict();
   end
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      sfr = '0;
      repeat (4) @(posedge mclk_i);
      #1 reset_n_i = 1'b1;
      rd(`CRBT_CTRL_ADDR, `CRBT_CTRL_RESET);
      rd(8'h00, 8'h00);
      wr(`CRBT_CNT_L_ADDR, 8'h34);
      repeat (20) @(posedge mclk_i);
      rd(`CRBT_CNT_L_ADDR, 8'h34);
      // Full-rate reload from fff0; overflow every sixteen cycles after the first wrap.
      wr(`CRBT_CLKCTL_ADDR, 8'h40);
      wr(`CRBT_RCAP_L_ADDR, 8'hf0);
      wr(`CRBT_RCAP_H_ADDR, 8'hff);
      wr(`CRBT_CNT_L_ADDR, 8'hf8);
      wr(`CRBT_CNT_H_ADDR, 8'hff);
      wr(`CRBT_CTRL_ADDR, 8'h04);
      repeat (10) @(posedge mclk_i);
      rd(`CRBT_CTRL_ADDR, 8'h84);
      check("irq_o", 8'h01, {7'h00, irq_o});
      wr(`CRBT_CTRL_ADDR, 8'h04);
      rd(`CRBT_CTRL_ADDR, 8'h04);
      wr(`CRBT_CTRL_ADDR, 8'h00);
      rd(`CRBT_CNT_H_ADDR, 8'hff);
      rd(`CRBT_CNT_L_ADDR, 8'hfa);
      // Capture of a pin-driven count.
      lo = 8'($random(seed)) & 8'h3f;
      wr(`CRBT_CNT_H_ADDR, 8'h00);
      wr(`CRBT_CNT_L_ADDR, lo);
      wr(`CRBT_CTRL_ADDR, 8'h0f);
      repeat (5) pins.fall(1'b0);
      pins.fall(1'b1);
      rd(`CRBT_RCAP_L_ADDR, lo + 8'h05);
      rd(`CRBT_RCAP_H_ADDR, 8'h00);
      rd(`CRBT_CTRL_ADDR, 8'h4f);
      wr(`CRBT_CTRL_ADDR, 8'h07);
      pins.fall(1'b1);
      rd(`CRBT_CTRL_ADDR, 8'h07);
      // Trigger reload in auto-reload mode.
      wr(`CRBT_CNT_L_ADDR, 8'h80);
      wr(`CRBT_CTRL_ADDR, 8'h0e);
      pins.fall(1'b1);
      rd(`CRBT_CNT_L_ADDR, lo + 8'h05);
      rd(`CRBT_CTRL_ADDR, 8'h4e);
      // Baud mode at half clock from fffe: one overflow every four cycles.
      wr(`CRBT_RCAP_L_ADDR, 8'hfe);
      wr(`CRBT_RCAP_H_ADDR, 8'hff);
      wr(`CRBT_CNT_L_ADDR, 8'hfe);
      wr(`CRBT_CNT_H_ADDR, 8'hff);
      wr(`CRBT_CTRL_ADDR, 8'h3c);
      r0 = rx_n;
      repeat (40) @(posedge mclk_i);
      if (rx_n - r0 < 9 || rx_n - r0 > 11) check("rx pulses", 8'h0a, 8'(rx_n - r0));
      check("tx pulses", 8'(rx_n), 8'(tx_n));
      pins.fall(1'b1);
      rd(`CRBT_CTRL_ADDR, 8'h7c);
      wr(`CRBT_CTRL_ADDR, 8'h00);
      // A last baud pulse may still leave the edge that stopped the mode.
      repeat (2) @(posedge mclk_i);
      r0 = rx_n;
      t0 = tx_n;
      pins.pulse_t1(3);
      check("rx from timer 1", 8'h03, 8'(rx_n - r0));
      check("tx from timer 1", 8'h03, 8'(tx_n - t0));
      // Divide by twelve: 120 enabled cycles hold exactly ten prescaler ticks.
      wr(`CRBT_CLKCTL_ADDR, 8'h00);
      wr(`CRBT_CNT_L_ADDR, 8'h00);
      wr(`CRBT_CNT_H_ADDR, 8'h00);
      wr(`CRBT_CTRL_ADDR, 8'h04);
      repeat (118) @(posedge mclk_i);
      wr(`CRBT_CTRL_ADDR, 8'h00);
      rd(`CRBT_CNT_L_ADDR, 8'h0a);
      // Baud mode on count-pin edges: two falls from fffe give one overflow.
      wr(`CRBT_CNT_L_ADDR, 8'hfe);
      wr(`CRBT_CNT_H_ADDR, 8'hff);
      wr(`CRBT_CTRL_ADDR, 8'h36);
      r0 = rx_n;
      repeat (2) pins.fall(1'b0);
      check("rx on pin edges", 8'h01, 8'(rx_n - r0));
      give_verdict();
   end
endmodule
`default_nettype wire
